// ---- core/atsc_top.v ----
`include "atsc_consts.vh"
`default_nettype none
// Operation
// - A falling edge on the convert-start input begins a ten-bit conversion.
// - The sampling stage holds from that falling edge and tracks again when conversion ends.
// - Convert-start is sampled at conversion end and a low level enters power-down.
// - A temperature conversion above the threshold word drives the alert low.
// - A rising read/write select edge starting a read releases the alert high.
// - Output bits launch on falling serial-clock edges and inputs are captured on rising edges.
// - The data output goes high impedance on falling read/write select or rising chip select.
// - The channel is chosen only by a serial write into the channel address register.
// - The single-channel variant uses one two-way data pin for input and output.
// - The serial port responds only while chip select is low.
// - Busy stays high for the whole conversion and falls on completion.
// - A control byte with five zero upper bits loads the channel, otherwise the threshold.
// - The threshold compares against the upper eight bits of the temperature result.
module atsc_top (
    input  wire                    SYS_CLK_I,
    input  wire                    RST_I,
    input  wire                    CONVERT_START_N_I,
    input  wire                    SCLK_I,
    input  wire                    CS_N_I,
    input  wire                    RD_WR_I,
    input  wire                    DATA_I,
    input  wire [`ATSC_RES_W-1:0]  ADC_RESULT_I,
    output reg                     DATA_O,
    output reg                     DATA_OE_O,
    output reg                     BUSY_O,
    output reg                     OVERTEMP_ALERT_N_O,
    output reg                     HOLD_O,
    output reg                     POWER_DOWN_O,
    output reg  [`ATSC_CHAN_W-1:0] CHANNEL_O,
    output reg  [`ATSC_CTRL_W-1:0] THRESHOLD_O
);

    // ==========================================
    // Pin synchronisers
    // Three stages; a change counts once stages two and three agree
    // Data is read raw at a settled clock edge, long after it moved
    reg [2:0] cv_sync_reg;
    reg [2:0] sck_sync_reg;
    reg [2:0] cs_sync_reg;
    reg [2:0] rw_sync_reg;
    reg [2:0] din_sync_reg;
    reg       cv_reg;
    reg       sck_reg;
    reg       cs_reg;
    reg       rw_reg;

    // Shift all pins in
    always @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            cv_sync_reg  <= 3'h7;
            sck_sync_reg <= 3'h0;
            cs_sync_reg  <= 3'h7;
            rw_sync_reg  <= 3'h0;
            din_sync_reg <= 3'h0;
        end else begin
            cv_sync_reg  <= {cv_sync_reg[1:0], CONVERT_START_N_I};
            sck_sync_reg <= {sck_sync_reg[1:0], SCLK_I};
            cs_sync_reg  <= {cs_sync_reg[1:0], CS_N_I};
            rw_sync_reg  <= {rw_sync_reg[1:0], RD_WR_I};
            din_sync_reg <= {din_sync_reg[1:0], DATA_I};
        end
    end

    // Stages two and three agree: the pin level is trusted
    function settled(input [2:0] sync_v);
        settled = (sync_v[2] == sync_v[1]);
    endfunction

    // Filtered levels move only when the last two stages agree
    always @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            cv_reg  <= 1'b1;
            sck_reg <= 1'b0;
            cs_reg  <= 1'b1;
            rw_reg  <= 1'b0;
        end else begin
            if (settled(cv_sync_reg)) begin
                cv_reg <= cv_sync_reg[2];
            end
            if (settled(sck_sync_reg)) begin
                sck_reg <= sck_sync_reg[2];
            end
            if (settled(cs_sync_reg)) begin
                cs_reg <= cs_sync_reg[2];
            end
            if (settled(rw_sync_reg)) begin
                rw_reg <= rw_sync_reg[2];
            end
        end
    end

    // Edge events, one cycle each
    wire cv_fall  = cv_reg & ~cv_sync_reg[2] & ~cv_sync_reg[1];
    wire sck_rise = ~sck_reg & sck_sync_reg[2] & sck_sync_reg[1];
    wire sck_fall = sck_reg & ~sck_sync_reg[2] & ~sck_sync_reg[1];
    wire cs_rise  = ~cs_reg & cs_sync_reg[2] & cs_sync_reg[1];
    wire rw_rise  = ~rw_reg & rw_sync_reg[2] & rw_sync_reg[1];
    wire rw_fall  = rw_reg & ~rw_sync_reg[2] & ~rw_sync_reg[1];
    wire cs_act   = ~cs_reg;

    // ==========================================
    // Conversion sequencer
    // Start edges that arrive mid-conversion are dropped, not queued
    localparam ST_IDLE = 1'b0;
    localparam ST_CONV = 1'b1;

    reg                     state_reg;
    reg [`ATSC_CNT_W-1:0]   cnt_reg;
    reg [`ATSC_RES_W-1:0]   result_reg;
    reg [`ATSC_CHAN_W-1:0]  conv_chan_reg;
    wire                    conv_done = (state_reg == ST_CONV) &&
                                        (cnt_reg == `ATSC_CONV_CYC - 1);

    // Channel latched at start so a write mid-conversion cannot corrupt it
    always @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            state_reg     <= ST_IDLE;
            cnt_reg       <= {`ATSC_CNT_W{1'b0}};
            result_reg    <= {`ATSC_RES_W{1'b0}};
            conv_chan_reg <= `ATSC_CHAN_TEMP;
            BUSY_O        <= 1'b0;
            HOLD_O        <= 1'b0;
            POWER_DOWN_O  <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (cv_fall) begin
                        state_reg     <= ST_CONV;
                        cnt_reg       <= {`ATSC_CNT_W{1'b0}};
                        conv_chan_reg <= CHANNEL_O;
                        BUSY_O        <= 1'b1;
                        HOLD_O        <= 1'b1;
                        POWER_DOWN_O  <= 1'b0;
                    end
                end
                ST_CONV: begin
                    if (conv_done) begin
                        state_reg    <= ST_IDLE;
                        result_reg   <= ADC_RESULT_I;
                        BUSY_O       <= 1'b0;
                        HOLD_O       <= 1'b0;
                        POWER_DOWN_O <= ~cv_reg;
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================
    // Serial port
    reg [`ATSC_RES_W-1:0]  tx_reg;
    reg [`ATSC_CTRL_W-1:0] rx_reg;
    reg [3:0]              rx_cnt_reg;
    // Chip select must settle low before the select line rises, or the
    // read is not taken; a cut frame loses its bits when either edge comes
    wire                   rd_edge = rw_rise & cs_act;

    // Temperature result above threshold, upper eight bits only
    wire over_temp = (conv_chan_reg == `ATSC_CHAN_TEMP) &&
                     (ADC_RESULT_I[`ATSC_RES_W-1:`ATSC_RES_W-`ATSC_CTRL_W] >
                      THRESHOLD_O);
    wire [`ATSC_CTRL_W-1:0] rx_byte = {rx_reg[`ATSC_CTRL_W-2:0], din_sync_reg[2]};

    // Shift register, output enable and register loads
    always @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            tx_reg             <= {`ATSC_RES_W{1'b0}};
            rx_reg             <= {`ATSC_CTRL_W{1'b0}};
            rx_cnt_reg         <= 4'h0;
            DATA_O             <= 1'b0;
            DATA_OE_O          <= 1'b0;
            CHANNEL_O          <= `ATSC_CHAN_TEMP;
            THRESHOLD_O        <= `ATSC_THRESH_RST;
            OVERTEMP_ALERT_N_O <= 1'b1;
        end else begin
            // Alert: a fresh conversion result beats a same-cycle release
            if (conv_done && conv_chan_reg == `ATSC_CHAN_TEMP) begin
                OVERTEMP_ALERT_N_O <= ~over_temp;
            end else if (rd_edge) begin
                OVERTEMP_ALERT_N_O <= 1'b1;
            end
            if (rd_edge) begin
                // Rising select with chip select low: load latest result
                tx_reg     <= result_reg;
                DATA_OE_O  <= 1'b0;
                rx_cnt_reg <= 4'h0;
            end else if (rw_fall || cs_rise) begin
                DATA_OE_O  <= 1'b0;
                rx_cnt_reg <= 4'h0;
            end else if (cs_act && rw_reg && sck_fall) begin
                // Launch next bit on the falling serial clock
                DATA_O    <= tx_reg[`ATSC_RES_W-1];
                DATA_OE_O <= 1'b1;
                tx_reg    <= {tx_reg[`ATSC_RES_W-2:0], 1'b0};
            end else if (cs_act && !rw_reg && sck_rise) begin
                // Capture on rising edge; decode after eight bits
                rx_reg <= rx_byte;
                if (rx_cnt_reg == `ATSC_CTRL_W - 1) begin
                    rx_cnt_reg <= 4'h0;
                    if (rx_byte[`ATSC_CTRL_W-1:`ATSC_CHAN_W] == `ATSC_UPPER_ZERO) begin
                        CHANNEL_O <= rx_byte[`ATSC_CHAN_W-1:0];
                    end else begin
                        THRESHOLD_O <= rx_byte;
                    end
                end else begin
                    rx_cnt_reg <= rx_cnt_reg + 1'b1;
                end
            end
        end
    end

endmodule
`default_nettype wire

// ---- core/atsc_consts.vh ----
`ifndef ATSC_CONSTS_VH
`define ATSC_CONSTS_VH
// ==========================================
// Widths
`define ATSC_RES_W          10
`define ATSC_CTRL_W         8
`define ATSC_CHAN_W         3
`define ATSC_CNT_W          9
// ==========================================
// Reset values and codes
`define ATSC_CHAN_TEMP      3'h0
`define ATSC_THRESH_RST     8'h99
`define ATSC_UPPER_ZERO     5'h00
// ==========================================
// Conversion timing: 9000 ns at a 40 ns clock period
`define ATSC_CONV_NS        9000
`define ATSC_CLK_NS         40
`define ATSC_CONV_CYC       ((`ATSC_CONV_NS + `ATSC_CLK_NS - 1) / `ATSC_CLK_NS)
`endif

// ---- sim/atsc_chk_asserts.sv ----
`include "atsc_consts.vh"
`default_nettype none
// ======
// Port checker
module atsc_chk (
    input wire logic                    SYS_CLK_I,
    input wire logic                    RST_I,
    input wire logic                    CONVERT_START_N_I,
    input wire logic                    CS_N_I,
    input wire logic                    RD_WR_I,
    input wire logic                    BUSY_O,
    input wire logic                    HOLD_O,
    input wire logic                    POWER_DOWN_O,
    input wire logic                    DATA_OE_O,
    input wire logic                    OVERTEMP_ALERT_N_O,
    input wire logic [`ATSC_CHAN_W-1:0] CHANNEL_O,
    input wire logic [`ATSC_CTRL_W-1:0] THRESHOLD_O
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (RST_I);
    // Pin edges need three to four clocks through the synchronisers
    property p_start; $fell(CONVERT_START_N_I) && !BUSY_O |-> ##[3:6] BUSY_O; endproperty
    a_start: assert property (p_start) else $error("start edge missed");
    property p_hold; BUSY_O == HOLD_O; endproperty
    a_hold: assert property (p_hold) else $error("hold differs from busy");
    property p_busy; $rose(BUSY_O) |-> ##224 BUSY_O ##1 !BUSY_O; endproperty
    a_busy: assert property (p_busy) else $error("busy length wrong");
    property p_pd; $fell(BUSY_O) |-> POWER_DOWN_O == !CONVERT_START_N_I; endproperty
    a_pd: assert property (p_pd) else $error("power-down level wrong");
    property p_oe; $fell(RD_WR_I) || $rose(CS_N_I) |-> ##[1:6] !DATA_OE_O; endproperty
    a_oe: assert property (p_oe) else $error("data pin still driven");
    property p_cs; CS_N_I [*8] |-> !DATA_OE_O; endproperty
    a_cs: assert property (p_cs) else $error("driving while deselected");
    property p_alert; $fell(OVERTEMP_ALERT_N_O) |-> $fell(BUSY_O); endproperty
    a_alert: assert property (p_alert) else $error("alert outside conversion end");
    property p_chan; $changed(CHANNEL_O) |-> $stable(THRESHOLD_O) && !RD_WR_I; endproperty
    a_chan: assert property (p_chan) else $error("channel changed outside write");
    // Release only by a selected read edge or a cool temperature result
    property p_release;
        $rose(OVERTEMP_ALERT_N_O) |-> $fell(BUSY_O) || (RD_WR_I && !CS_N_I);
    endproperty
    a_release: assert property (p_release) else $error("alert released without cause");
    c_alert: cover property ($fell(OVERTEMP_ALERT_N_O));
    c_pd: cover property ($rose(POWER_DOWN_O));
    c_read: cover property ($rose(DATA_OE_O));
    c_release: cover property ($rose(OVERTEMP_ALERT_N_O));
endmodule
bind atsc_top atsc_chk u_chk (
    .SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I), .CONVERT_START_N_I(CONVERT_START_N_I),
    .CS_N_I(CS_N_I), .RD_WR_I(RD_WR_I), .BUSY_O(BUSY_O), .HOLD_O(HOLD_O),
    .POWER_DOWN_O(POWER_DOWN_O), .DATA_OE_O(DATA_OE_O),
    .OVERTEMP_ALERT_N_O(OVERTEMP_ALERT_N_O), .CHANNEL_O(CHANNEL_O),
    .THRESHOLD_O(THRESHOLD_O));
`default_nettype wire

// ---- sim/atsc_host.sv ----
`default_nettype none
// ======
// Host model: serial port and start pin
module atsc_host (
    input  wire logic clk_i,
    input  wire logic data_i,
    output var  logic sclk_o,
    output var  logic cs_n_o,
    output var  logic rd_wr_o,
    output var  logic data_oe_o,
    output var  logic data_o,
    output var  logic convert_start_n_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle levels; link clock parked high between frames
    initial begin
        sclk_o = 1'b1;
        cs_n_o = 1'b1;
        rd_wr_o = 1'b0;
        data_oe_o = 1'b0;
        data_o = 1'b0;
        convert_start_n_o = 1'b1;
    end
    // Changes land just after a clock edge
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // Byte MSB first, set while low, taken on the rise
    task automatic wr(input logic [7:0] b, input logic cs_n);
        cs_n_o = cs_n;
        rd_wr_o = 1'b0;
        data_oe_o = 1'b1;
        step(4);
        for (int i = 7; i >= 0; i--) begin
            sclk_o = 1'b0;
            data_o = b[i];
            step(4);
            sclk_o = 1'b1;
            step(4);
        end
        step(4);
        data_oe_o = 1'b0;
        cs_n_o = 1'b1;
        step(4);
    endtask
    // Chip select settles before the select rises; sampled late in the high half
    task automatic rd(output logic [9:0] v, input logic end_cs);
        v = 10'h000;
        cs_n_o = 1'b0;
        step(4);
        rd_wr_o = 1'b1;
        step(6);
        repeat (10) begin
            sclk_o = 1'b0;
            step(4);
            sclk_o = 1'b1;
            step(4);
            v = {v[8:0], data_i};
        end
        // Either chip select or the select line ends the read
        if (end_cs) begin
            cs_n_o = 1'b1;
            step(8);
            rd_wr_o = 1'b0;
        end else begin
            rd_wr_o = 1'b0;
            step(8);
            cs_n_o = 1'b1;
        end
        step(4);
    endtask
    // Holding start low through the end selects power-down
    task automatic conv(input logic pd);
        convert_start_n_o = 1'b0;
        step(8);
        convert_start_n_o = !pd;
        step(240);
    endtask
endmodule
`default_nettype wire

// ---- sim/test_adc_temp_serial_control.sv ----
`include "atsc_consts.vh"
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_mismatch++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
// ======
// Bench top
module test_adc_temp_serial_control;
    timeunit 1ns;
    timeprecision 100ps;
    logic                    clk = 1'b0;
    logic                    rst = 1'b1;
    logic [9:0]              result = 10'h26B;
    logic [9:0]              rdv;
    int                      n_mismatch = 0;
    int                      total_checks = 0;
    wire logic               sclk, cs_n, rd_wr, hd, hoe, cnv, pin, d_o, d_oe;
    wire logic               busy, alert, hold, pd;
    wire logic [`ATSC_CHAN_W-1:0] chan;
    wire logic [`ATSC_CTRL_W-1:0] thr;
    // Released pin shows the inverse so stale data never matches
    assign pin = d_oe ? d_o : (hoe ? hd : ~hd);
    always #20 clk = ~clk;
    atsc_top dut (.SYS_CLK_I(clk), .RST_I(rst), .CONVERT_START_N_I(cnv), .SCLK_I(sclk),
        .CS_N_I(cs_n), .RD_WR_I(rd_wr), .DATA_I(pin), .ADC_RESULT_I(result), .DATA_O(d_o),
        .DATA_OE_O(d_oe), .BUSY_O(busy), .OVERTEMP_ALERT_N_O(alert), .HOLD_O(hold),
        .POWER_DOWN_O(pd), .CHANNEL_O(chan), .THRESHOLD_O(thr));
    atsc_host host (.clk_i(clk), .data_i(pin), .sclk_o(sclk), .cs_n_o(cs_n), .rd_wr_o(rd_wr),
        .data_oe_o(hoe), .data_o(hd), .convert_start_n_o(cnv));
    task automatic end_of_test;
        $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Sequence needs about 50 us
    initial begin
        #200000;
        n_mismatch++;
        end_of_test;
    end
    // Main sequence
    initial begin
        repeat (5) @(posedge clk);
        #1 rst = 1'b0;
        host.step(4);
        `CHK({thr, chan, alert}, 12'h991)
        host.conv(1'b0);
        `CHK({alert, pd, busy, hold}, 4'h0)
        host.rd(rdv, 1'b0);
        `CHK(rdv, 10'h26B)
        `CHK({alert, d_oe}, 2'h2)
        host.wr(8'h03, 1'b0);
        `CHK({thr, chan}, 11'h4CB)
        result = 10'h3FF;
        host.conv(1'b0);
        `CHK(alert, 1'b1)
        host.wr(8'hFF, 1'b0);
        host.wr(8'h00, 1'b0);
        `CHK({thr, chan}, 11'h7F8)
        host.conv(1'b1);
        `CHK({alert, pd}, 2'h3)
        host.rd(rdv, 1'b1);
        `CHK({rdv, d_oe}, 11'h7FE)
        host.wr(8'h05, 1'b1);
        `CHK(chan, 3'h0)
        end_of_test;
    end
endmodule
`default_nettype wire
